// ---- sdc_ctrl.sv ----
// Memory controller end: start-up sequence, single-word accesses, sleep
`timescale 1ns/1ps
module sdc_ctrl
    import sdc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    sdc_if.ctrl                    pins,
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [BANK_W-1:0] reqBank,
    input  wire logic [ADDR_W-1:0] reqRow,
    input  wire logic [COL_W-1:0]  reqCol,
    input  wire logic [DQ_W-1:0]   reqWrData,
    input  wire logic [LANES-1:0]  reqMask,
    output logic                   reqReady,
    output logic                   rdValid,
    output logic [DQ_W-1:0]        rdData,
    input  wire logic              sleepReq,
    output logic                   sleeping,
    output logic                   initDone
);
    typedef enum logic [2:0] {
        CS_PRE_ALL  = 3'b000,
        CS_LOAD_MR  = 3'b001,
        CS_LOAD_EMR = 3'b010,
        CS_IDLE     = 3'b011,
        CS_ACCESS   = 3'b100,
        CS_CAPTURE  = 3'b101,
        CS_SLEEP    = 3'b110
    } sdc_cstate_t;

    sdc_cstate_t       state_q;
    logic [3:0]        waitCnt_q;
    sdc_cmd_t          cmd_q;
    logic              cke_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic [LANES-1:0]  mask_q;
    logic [DQ_W-1:0]   dqOut_q;
    logic [LANES-1:0]  dqOe_q;
    logic              write_q;
    logic [COL_W-1:0]  col_q;
    logic [DQ_W-1:0]   wrData_q;
    logic [LANES-1:0]  wrMask_q;
    logic              rdValid_q;
    logic [DQ_W-1:0]   rdData_q;

    // Accept a request only in idle with every bank closed
    assign reqReady = (state_q == CS_IDLE) && (waitCnt_q == '0) && !sleepReq;

    // Command sequencer; wait counter inserts idle cycles between commands
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q   <= CS_PRE_ALL;
            waitCnt_q <= '0;
            cmd_q     <= CMD_NOP;
            cke_q     <= 1'b1;
            bank_q    <= '0;
            addr_q    <= '0;
            mask_q    <= '0;
            dqOut_q   <= '0;
            dqOe_q    <= '0;
            write_q   <= 1'b0;
            col_q     <= '0;
            wrData_q  <= '0;
            wrMask_q  <= '0;
        end else begin
            cmd_q  <= CMD_NOP;
            mask_q <= '0;
            dqOe_q <= '0;
            if (waitCnt_q != '0) begin
                waitCnt_q <= waitCnt_q - 4'h1;
            end else begin
                case (state_q)
                    CS_PRE_ALL: begin
                        cmd_q            <= CMD_PRE;
                        addr_q           <= '0;
                        addr_q[PREC_BIT] <= 1'b1;
                        waitCnt_q        <= 4'(RP_CYC - 1);
                        state_q          <= CS_LOAD_MR;
                    end
                    CS_LOAD_MR: begin
                        cmd_q     <= CMD_MRS; // RQ20
                        bank_q    <= MR_BANK;
                        addr_q    <= MR_OPCODE; // RQ10
                        waitCnt_q <= 4'(MRD_CYC - 1);
                        state_q   <= CS_LOAD_EMR;
                    end
                    CS_LOAD_EMR: begin
                        cmd_q     <= CMD_MRS;
                        bank_q    <= EMR_BANK; // RQ21
                        addr_q    <= EMR_OPCODE;
                        waitCnt_q <= 4'(MRD_CYC - 1); // RQ20
                        state_q   <= CS_IDLE;
                    end
                    CS_IDLE: begin
                        if (sleepReq) begin
                            cke_q   <= 1'b0; // RQ4
                            state_q <= CS_SLEEP;
                        end else if (reqValid) begin
                            cmd_q     <= CMD_ACT;
                            bank_q    <= reqBank; // RQ6
                            addr_q    <= reqRow; // RQ7
                            write_q   <= reqWrite;
                            col_q     <= reqCol;
                            wrData_q  <= reqWrData;
                            wrMask_q  <= reqMask;
                            waitCnt_q <= 4'(RCD_CYC - 1);
                            state_q   <= CS_ACCESS; // RQ23
                        end
                    end
                    CS_ACCESS: begin
                        cmd_q            <= write_q ? CMD_WR : CMD_RD;
                        addr_q           <= '0;
                        addr_q[COL_W-1:0] <= col_q;
                        addr_q[PREC_BIT] <= 1'b1;
                        mask_q           <= wrMask_q;
                        if (write_q) begin
                            dqOut_q   <= wrData_q;
                            dqOe_q    <= '1;
                            waitCnt_q <= 4'(RP_CYC - 1);
                            state_q   <= CS_IDLE;
                        end else begin
                            // The read command reaches the pins one edge later, so wait a full CL to sample at the latency edge
                            waitCnt_q <= 4'(CL_CYC);
                            state_q   <= CS_CAPTURE;
                        end
                    end
                    CS_CAPTURE: begin
                        state_q <= CS_IDLE;
                    end
                    CS_SLEEP: begin
                        if (!sleepReq) begin
                            cke_q     <= 1'b1;
                            waitCnt_q <= 4'h1;
                            state_q   <= CS_IDLE;
                        end
                    end
                    default: begin
                        state_q <= CS_PRE_ALL;
                    end
                endcase
            end
        end
    end

    // Read capture at the latency edge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdValid_q <= 1'b0;
            rdData_q  <= '0;
        end else begin
            rdValid_q <= (state_q == CS_CAPTURE) && (waitCnt_q == '0);
            if ((state_q == CS_CAPTURE) && (waitCnt_q == '0)) begin
                rdData_q <= pins.dataPins; // RQ19
            end
        end
    end

    // Pin drive
    assign pins.cke        = cke_q;
    assign pins.csN        = cmd_q[3];
    assign pins.rasN       = cmd_q[2];
    assign pins.casN       = cmd_q[1];
    assign pins.weN        = cmd_q[0];
    assign pins.bankSelect = bank_q;
    assign pins.addrBus    = addr_q;
    assign pins.byteMask   = mask_q;
    assign pins.ctrlDqOut  = dqOut_q;
    assign pins.ctrlDqOe   = dqOe_q;
    assign rdValid         = rdValid_q;
    assign rdData          = rdData_q;
    assign sleeping        = (state_q == CS_SLEEP);
    assign initDone        = (state_q != CS_PRE_ALL) && (state_q != CS_LOAD_MR) &&
                             (state_q != CS_LOAD_EMR);
endmodule

// ---- sdc_device.sv ----
// DRAM device end: command decode, banks, bursts, byte masks and clock gating
`timescale 1ns/1ps
// Operation
// [RQ1] Sample all inputs on rising clock only
// [RQ2] Burst counter and outputs advance per clock
// [RQ3] Gate low suspends clock, freezes outputs
// [RQ4] Gate low with banks idle powers down
// [RQ5] Power-down ignores inputs except clock gate
// [RQ6] Bank select picks the target bank
// [RQ7] Row open latches thirteen-bit row
// [RQ8] Column from low nine bits, bit ten autoprecharge
// [RQ9] Precharge bit ten high closes all banks
// [RQ10] Mode set loads opcode from address
// [RQ11] Chip select high masks every command
// [RQ12] Row-open code activates selected bank
// [RQ13] Precharge code returns bank to idle
// [RQ14] Column access starts on column strobe
// [RQ15] Byte mask acts per cycle, floats lanes
// [RQ16] Masked write lanes leave memory unchanged
// [RQ17] Read mask suppresses output two clocks later
// [RQ18] Mask bit n governs data byte n
// [RQ19] Data moves on rising clock edge
// [RQ20] Controller loads mode only when idle
// [RQ21] Bank code two selects extended mode register
// [RQ22] Write select high reads, low writes
// [RQ23] Controller accesses only opened banks
module sdc_device
    import sdc_pkg::*;
#(
    parameter int MEM_ROW_BITS = 2
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    sdc_if.dev                     pins,
    output sdc_pwr_t               pwrState,
    output logic [BANKS-1:0]       bankOpen,
    output logic [ADDR_W-1:0]      baseModeReg,
    output logic [ADDR_W-1:0]      extendedModeReg
);
    localparam int MEM_AW = BANK_W + MEM_ROW_BITS + COL_W;

    logic [DQ_W-1:0]   mem [2**MEM_AW];
    sdc_pwr_t          pwr_q;
    logic [BANKS-1:0]  bankOpen_q;
    logic [ADDR_W-1:0] rowAddr_q [BANKS];
    logic [ADDR_W-1:0] mr_q;
    logic [ADDR_W-1:0] emr_q;
    logic              burstActive_q;
    logic              burstWrite_q;
    logic              burstAp_q;
    logic [BANK_W-1:0] burstBank_q;
    logic [COL_W-1:0]  burstStart_q;
    logic [COL_W-1:0]  burstCnt_q;
    logic [2:0]        rdValid_q;
    logic [DQ_W-1:0]   rdData_q [3];
    logic [LANES-1:0]  maskD1_q;
    logic [LANES-1:0]  maskD2_q;

    sdc_cmd_t          cmd;
    logic              run;
    logic              colCmd;
    logic              accValid;
    logic              accWrite;
    logic [BANK_W-1:0] accBank;
    logic [COL_W-1:0]  accCol;
    logic [COL_W-1:0]  accCnt;
    logic [COL_W-1:0]  burstMask;
    logic              burstEnd;
    logic [MEM_AW-1:0] accIdx;
    logic [1:0]        clTap;

    // Chip select high forces the deselect code, so nothing below acts on it
    always_comb begin
        if (pins.csN) begin
            cmd = CMD_DESEL; // RQ11
        end else begin
            cmd = sdc_cmd_t'({1'b0, pins.rasN, pins.casN, pins.weN});
        end
    end

    // Internal clock runs only in the run state; all else freezes
    assign run    = (pwr_q == PWR_RUN); // RQ3
    assign colCmd = run && (cmd == CMD_RD || cmd == CMD_WR); // RQ14

    // Burst length as a wrap mask: 1, 2, 4, 8 or full page
    always_comb begin
        case (mr_q[BL_LSB +: 3])
            3'h0:    burstMask = 9'h000;
            3'h1:    burstMask = 9'h001;
            3'h2:    burstMask = 9'h003;
            3'h3:    burstMask = 9'h007;
            3'h7:    burstMask = 9'h1FF;
            default: burstMask = 9'h000;
        endcase
    end

    // Read latency tap from the mode register
    always_comb begin
        case (mr_q[CL_LSB +: 3])
            3'h1:    clTap = 2'd0;
            3'h3:    clTap = 2'd2;
            default: clTap = 2'd1;
        endcase
    end

    // Access of this cycle: a new column command wins over a running burst
    always_comb begin
        accValid = colCmd || (run && burstActive_q);
        if (colCmd) begin
            accWrite = (cmd == CMD_WR); // RQ22
            accBank  = pins.bankSelect; // RQ6
            accCnt   = '0;
            accCol   = pins.addrBus[COL_W-1:0]; // RQ8
        end else begin
            accWrite = burstWrite_q;
            accBank  = burstBank_q;
            accCnt   = burstCnt_q;
            if (mr_q[BT_BIT]) begin
                accCol = burstStart_q ^ burstCnt_q;
            end else begin
                accCol = (burstStart_q & ~burstMask) |
                         ((burstStart_q + burstCnt_q) & burstMask);
            end
        end
        burstEnd = (accCnt == burstMask) && (burstMask != 9'h1FF);
        accIdx   = {accBank, rowAddr_q[accBank][MEM_ROW_BITS-1:0], accCol};
    end

    // Clock gate: suspend, or power-down / self-refresh when all banks idle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pwr_q <= PWR_RUN;
        end else if (run) begin
            if (!pins.cke) begin // RQ3
                if (bankOpen_q == '0 && !burstActive_q) begin
                    pwr_q <= (cmd == CMD_REF) ? PWR_SELFREF : PWR_DOWN; // RQ4
                end else begin
                    pwr_q <= PWR_SUSPEND;
                end
            end
        end else if (pins.cke) begin
            pwr_q <= PWR_RUN; // RQ5
        end
    end

    // Bank state and row latches
    always_ff @(posedge sys_clk) begin // RQ1
        if (!resetn) begin
            bankOpen_q <= '0;
            for (int b = 0; b < BANKS; b++) begin
                rowAddr_q[b] <= '0;
            end
        end else if (run) begin
            if (cmd == CMD_ACT) begin // RQ12
                bankOpen_q[pins.bankSelect] <= 1'b1;
                rowAddr_q[pins.bankSelect]  <= pins.addrBus; // RQ7
            end else if (cmd == CMD_PRE) begin // RQ13
                if (pins.addrBus[PREC_BIT]) begin
                    bankOpen_q <= '0; // RQ9
                end else begin
                    bankOpen_q[pins.bankSelect] <= 1'b0;
                end
            end else if (accValid && burstEnd && (colCmd ? pins.addrBus[PREC_BIT]
                                                          : burstAp_q)) begin
                bankOpen_q[accBank] <= 1'b0; // RQ8
            end
        end
    end

    // Mode registers; bank code selects base or extended
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mr_q  <= MR_RESET;
            emr_q <= EMR_RESET;
        end else if (run && cmd == CMD_MRS) begin
            if (pins.bankSelect == EMR_BANK) begin
                emr_q <= pins.addrBus; // RQ21
            end else if (pins.bankSelect == MR_BANK) begin
                mr_q <= pins.addrBus; // RQ10
            end
        end
    end

    // Burst counter; frozen while the internal clock is stopped
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            burstActive_q <= 1'b0;
            burstWrite_q  <= 1'b0;
            burstAp_q     <= 1'b0;
            burstBank_q   <= '0;
            burstStart_q  <= '0;
            burstCnt_q    <= '0;
        end else if (run) begin // RQ2
            if (colCmd) begin
                burstWrite_q <= (cmd == CMD_WR);
                burstAp_q    <= pins.addrBus[PREC_BIT]; // RQ8
                burstBank_q  <= pins.bankSelect;
                burstStart_q <= pins.addrBus[COL_W-1:0];
            end
            if (cmd == CMD_PRE && (pins.addrBus[PREC_BIT] || pins.bankSelect == burstBank_q)
                && !colCmd) begin
                burstActive_q <= 1'b0;
            end else if (accValid) begin
                burstActive_q <= !burstEnd;
                burstCnt_q    <= (accCnt + 9'h001) & burstMask;
            end
        end
    end

    // Write lanes: masked bytes keep their old contents
    always_ff @(posedge sys_clk) begin
        if (accValid && accWrite) begin // RQ19
            for (int i = 0; i < LANES; i++) begin
                if (!pins.byteMask[i]) begin // RQ16 RQ18
                    mem[accIdx][8*i +: 8] <= pins.dataPins[8*i +: 8];
                end
            end
        end
    end

    // Read pipeline feeding the output register at the programmed latency
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdValid_q <= '0;
            for (int k = 0; k < 3; k++) begin
                rdData_q[k] <= '0;
            end
        end else if (run) begin // RQ2
            rdValid_q   <= {rdValid_q[1:0], accValid && !accWrite};
            rdData_q[0] <= mem[accIdx];
            rdData_q[1] <= rdData_q[0];
            rdData_q[2] <= rdData_q[1];
        end
    end

    // Byte mask delay line: sampled mask hits the output two clocks later
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            maskD1_q <= '0;
            maskD2_q <= '0;
        end else if (run) begin
            maskD1_q <= pins.byteMask; // RQ17
            maskD2_q <= maskD1_q;
        end
    end

    // Lanes drive only for valid read data with no mask pending
    assign pins.devDqOut = rdData_q[clTap]; // RQ19
    assign pins.devDqOe  = {LANES{rdValid_q[clTap]}} & ~maskD2_q; // RQ15 RQ18

    // Status outputs
    assign pwrState        = pwr_q;
    assign bankOpen        = bankOpen_q;
    assign baseModeReg     = mr_q;
    assign extendedModeReg = emr_q;
endmodule

// ---- sdc_if.sv ----
// Pin bundle between memory controller and DRAM device
`timescale 1ns/1ps
interface sdc_if;
    import sdc_pkg::*;
    logic                cke;
    logic                csN;
    logic                rasN;
    logic                casN;
    logic                weN;
    logic [BANK_W-1:0]   bankSelect;
    logic [ADDR_W-1:0]   addrBus;
    logic [LANES-1:0]    byteMask;
    logic [DQ_W-1:0]     ctrlDqOut;
    logic [LANES-1:0]    ctrlDqOe;
    logic [DQ_W-1:0]     devDqOut;
    logic [LANES-1:0]    devDqOe;
    logic [DQ_W-1:0]     dataPins;

    // Resolve each byte lane of the shared data wires; an undriven lane reads zero
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign dataPins[8*i +: 8] = devDqOe[i]  ? devDqOut[8*i +: 8] :
                                    ctrlDqOe[i] ? ctrlDqOut[8*i +: 8] : 8'h00;
    end

    modport dev (
        input  cke, csN, rasN, casN, weN, bankSelect, addrBus, byteMask, dataPins,
        output devDqOut, devDqOe
    );
    modport ctrl (
        output cke, csN, rasN, casN, weN, bankSelect, addrBus, byteMask,
        output ctrlDqOut, ctrlDqOe,
        input  dataPins
    );
endinterface

// ---- sdc_link_properties.sv ----
// Concurrent checks on the pins between controller and device
`timescale 1ns/1ps
module sdc_link_properties
    import sdc_pkg::*;
(
    input logic              sys_clk,
    input logic              resetn,
    input logic              cke,
    input logic              csN,
    input logic              rasN,
    input logic              casN,
    input logic              weN,
    input logic [BANK_W-1:0] bankSelect,
    input logic [ADDR_W-1:0] addrBus,
    input logic [LANES-1:0]  byteMask,
    input logic [LANES-1:0]  ctrlDqOe,
    input logic [LANES-1:0]  devDqOe,
    input logic [DQ_W-1:0]   devDqOut
);
    // Command code as the device decodes it
    logic [3:0] cmd;
    assign cmd = {csN, rasN, casN, weN};

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_read_lane_mask: assert property (
        cmd == CMD_RD && cke |-> ##2 devDqOe == ~$past(byteMask, 2)
    ) else $error("read lanes do not follow mask");
    a_dev_drive_cause: assert property (
        devDqOe != 0 |-> $past(cmd, 2) == CMD_RD && $past(cke, 2)
    ) else $error("device drove data without read");
    a_no_contention: assert property (
        (devDqOe & ctrlDqOe) == 0
    ) else $error("both ends drive one lane");
    a_write_drive: assert property (
        cmd == CMD_WR |-> ctrlDqOe == 4'hf && devDqOe == 0
    ) else $error("write data not driven by controller");
    a_bank_opened: assert property (
        cmd == CMD_RD || cmd == CMD_WR |-> $past(cmd) == CMD_ACT && $past(bankSelect) == bankSelect
    ) else $error("column access to unopened bank");
    a_auto_close: assert property (
        cmd == CMD_RD || cmd == CMD_WR |-> addrBus[PREC_BIT]
    ) else $error("column access without autoprecharge");
    a_mode_idle: assert property (
        cmd == CMD_MRS |-> $past(cmd) == CMD_MRS || $past(cmd) == CMD_PRE && $past(addrBus[PREC_BIT])
    ) else $error("mode load with banks maybe open");
    a_mode_target: assert property (
        cmd == CMD_MRS |-> bankSelect == MR_BANK || bankSelect == EMR_BANK
    ) else $error("mode load to unknown register");
    a_sleep_idle: assert property (
        $fell(cke) |-> $past(cmd) == CMD_NOP && devDqOe == 0
    ) else $error("clock gate lowered while busy");
    a_suspend_freeze: assert property (
        !$past(cke) && !$past(cke, 2) |-> $stable(devDqOe) && $stable(devDqOut)
    ) else $error("outputs moved while clock gated");
endmodule

// ---- sdc_pkg.sv ----
// Shared constants, command codes and state types for the DRAM pin link
package sdc_pkg;
    // Bus widths
    localparam int DQ_W     = 32;
    localparam int ADDR_W   = 13;
    localparam int BANK_W   = 2;
    localparam int COL_W    = 9;
    localparam int LANES    = 4;
    localparam int BANKS    = 4;
    // Address field positions
    localparam int PREC_BIT = 10;      // precharge_scope_bit
    // Mode register field positions
    localparam int BL_LSB   = 0;
    localparam int BT_BIT   = 3;
    localparam int CL_LSB   = 4;
    // Mode register reset values and the bank codes of the base and extended registers
    localparam logic [ADDR_W-1:0] MR_RESET  = 13'h0020;
    localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
    localparam logic [BANK_W-1:0] EMR_BANK  = 2'h2;
    localparam logic [BANK_W-1:0] MR_BANK   = 2'h0;
    // Opcodes the controller loads at start-up: burst 1, sequential, latency 2
    localparam logic [ADDR_W-1:0] MR_OPCODE  = 13'h0020;
    localparam logic [ADDR_W-1:0] EMR_OPCODE = 13'h0000;
    // Read mask latency in clocks
    localparam int MASK_LAT = 2;
    // Timing, in ns, and the derived cycle counts (least times round up)
    localparam int CLK_NS   = 20;
    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS  = 20;
    localparam int T_MRD_NS = 20;
    localparam int RCD_CYC  = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC  = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CL_CYC   = 2;
    // Command code {chip select, row strobe, column strobe, write select}
    typedef enum logic [3:0] {
        CMD_MRS   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WR    = 4'h4,
        CMD_RD    = 4'h5,
        CMD_NOP   = 4'h7,
        CMD_DESEL = 4'h8
    } sdc_cmd_t;
    // Device clock state
    typedef enum logic [1:0] {
        PWR_RUN     = 2'b00,
        PWR_SUSPEND = 2'b01,
        PWR_DOWN    = 2'b10,
        PWR_SELFREF = 2'b11
    } sdc_pwr_t;
endpackage

// ---- tb_top.sv ----
// Testbench joining controller and device ends of the DRAM pin link
`timescale 1ns/1ps
module tb_top;
    import sdc_pkg::*;
    logic              sys_clk = 0;
    logic              resetn = 0;
    logic              reqValid = 0;
    logic              reqWrite = 0;
    logic              sleepReq = 0;
    logic [BANK_W-1:0] reqBank = '0;
    logic [ADDR_W-1:0] reqRow = '0;
    logic [COL_W-1:0]  reqCol = '0;
    logic [DQ_W-1:0]   reqWrData = '0;
    logic [LANES-1:0]  reqMask = '0;
    logic              reqReady, rdValid, sleeping, initDone;
    logic [DQ_W-1:0]   rdData;
    sdc_pwr_t          pwrState;
    logic [BANKS-1:0]  bankOpen;
    logic [ADDR_W-1:0] baseModeReg, extendedModeReg;
    int                miscompares = 0;
    int                n_checks = 0;

    // Both ends meet on one pin bundle
    sdc_if i_sdc_if ();
    sdc_ctrl i_sdc_ctrl (.sys_clk, .resetn, .pins(i_sdc_if.ctrl), .reqValid, .reqWrite, .reqBank,
        .reqRow, .reqCol, .reqWrData, .reqMask, .reqReady, .rdValid, .rdData, .sleepReq,
        .sleeping, .initDone);
    sdc_device #(.MEM_ROW_BITS(2)) i_sdc_device (.sys_clk, .resetn, .pins(i_sdc_if.dev),
        .pwrState, .bankOpen, .baseModeReg, .extendedModeReg);
    sdc_link_properties i_sdc_link_properties (.sys_clk, .resetn, .cke(i_sdc_if.cke),
        .csN(i_sdc_if.csN), .rasN(i_sdc_if.rasN), .casN(i_sdc_if.casN), .weN(i_sdc_if.weN),
        .bankSelect(i_sdc_if.bankSelect), .addrBus(i_sdc_if.addrBus),
        .byteMask(i_sdc_if.byteMask), .ctrlDqOe(i_sdc_if.ctrlDqOe),
        .devDqOe(i_sdc_if.devDqOe), .devDqOut(i_sdc_if.devDqOut));

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    task test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A bound that ran out ends the run
    task give_up(input int i, input int lim, input string what);
        if (i >= lim) begin
            check(what, 32'h0, 32'h1);
            test_done;
        end
    endtask

    // One request, held until the edge that takes it
    task access(input logic wr, input logic [1:0] b, input logic [12:0] r, input logic [8:0] c,
                input logic [31:0] d, input logic [3:0] m);
        int i;
        for (i = 0; i < 40 && reqReady !== 1'b1; i++) @(posedge sys_clk) #1;
        give_up(i, 40, "reqReady");
        reqValid = 1;
        reqWrite = wr;
        reqBank = b;
        reqRow = r;
        reqCol = c;
        reqWrData = d;
        reqMask = m;
        @(posedge sys_clk) #1;
        reqValid = 0;
    endtask

    task rd_check(input logic [1:0] b, input logic [12:0] r, input logic [8:0] c,
                  input logic [3:0] m, input logic [31:0] exp);
        int i;
        access(0, b, r, c, '0, m);
        for (i = 0; i < 10 && rdValid !== 1'b1; i++) @(posedge sys_clk) #1;
        give_up(i, 10, "rdValid");
        check("rdData", rdData, exp);
    endtask

    task test_init;
        int i;
        for (i = 0; i < 20 && initDone !== 1'b1; i++) @(posedge sys_clk) #1;
        give_up(i, 20, "initDone");
        // The extended register load lands one edge after initDone rises
        @(posedge sys_clk) #1;
        check("baseModeReg", 32'(baseModeReg), 32'(MR_OPCODE));
        check("extendedModeReg", 32'(extendedModeReg), 32'(EMR_OPCODE));
        check("bankOpen", 32'(bankOpen), 32'h0);
        $display("test_init done");
    endtask

    // Masked write keeps old lanes, masked read floats lanes for one access only
    task test_masks;
        access(1, 2'h1, 13'h0, 9'h1FF, 32'h1122_3344, 4'h0);
        access(1, 2'h1, 13'h0, 9'h1FF, 32'hAABB_CCDD, 4'h5);
        rd_check(2'h1, 13'h0, 9'h1FF, 4'h0, 32'hAA22_CC44);
        rd_check(2'h1, 13'h0, 9'h1FF, 4'hA, 32'h0022_0044);
        rd_check(2'h1, 13'h0, 9'h1FF, 4'h0, 32'hAA22_CC44);
        check("bankOpen", 32'(bankOpen), 32'h0);
        $display("test_masks done");
    endtask

    // Every bank and two rows hold their own words
    task test_banks;
        for (int b = 0; b < BANKS; b++) begin
            access(1, 2'(b), 13'(b), 9'h000, {4{8'(b + 8'h51)}}, 4'h0);
        end
        access(1, 2'h0, 13'h3, 9'h000, 32'h5A5A_A5A5, 4'h0);
        for (int b = 0; b < BANKS; b++) begin
            rd_check(2'(b), 13'(b), 9'h000, 4'h0, {4{8'(b + 8'h51)}});
        end
        rd_check(2'h0, 13'h3, 9'h000, 4'h0, 32'h5A5A_A5A5);
        $display("test_banks done");
    endtask

    // Sleep with banks idle, then wake and read old data
    task test_sleep;
        int i;
        sleepReq = 1;
        for (i = 0; i < 50 && pwrState !== PWR_DOWN; i++) @(posedge sys_clk) #1;
        give_up(i, 50, "pwrState");
        check("sleeping", 32'(sleeping), 32'h1);
        repeat (3) @(posedge sys_clk) #1;
        check("pwrState", 32'(pwrState), 32'(PWR_DOWN));
        sleepReq = 0;
        rd_check(2'h1, 13'h0, 9'h1FF, 4'h0, 32'hAA22_CC44);
        $display("test_sleep done");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk) #1;
        resetn = 1;
        test_init;
        test_masks;
        test_banks;
        test_sleep;
        test_done;
    end
endmodule
